// File: src/mult_decode.sv
/*
  Decodes the multiplier mode pins into a multiply factor and bypass flag.
  Assumes the mode pins are static straps sampled by the caller.
*/
`timescale 1ns/1ns
module mult_decode
  import pdcc_pkg::*;
(
  input wire pll_cfg_t cfg,
  output logic [3:0] factor,
  output logic bypass
);
  always_comb
  begin
    if (cfg.full_package)
    begin
      case (cfg.mult_sel)
        3'h0: factor = 4'h1;
        3'h1: factor = 4'h4;
        3'h2: factor = 4'h6;
        3'h3: factor = 4'h7;
        3'h4: factor = 4'h8;
        3'h5: factor = 4'h9;
        3'h6: factor = 4'ha;
        default: factor = 4'hb;
      endcase
    end
    else
    begin
      case (cfg.mult_sel[1:0])
        2'h0: factor = 4'h1;
        2'h1: factor = 4'h4;
        2'h2: factor = 4'h8;
        default: factor = 4'ha;
      endcase
    end
    bypass = (factor == 4'h1);
  end
endmodule

// File: src/pdcc_consts.svh
/*
  Offsets, field positions, reset values and timing counts for the
  clock and power-down control block.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef PDCC_CONSTS_SVH
`define PDCC_CONSTS_SVH

`define CORE_CLK_HZ 25000000
`define PCG_OFFSET 32'h019c0200
`define CCS_OFFSET 32'h019c0204
`define STAT_OFFSET 32'h019c0208
`define SLEEP_LSB 10
`define SLEEP_MSB 15
`define SLEEP_RSV 15
`define GIE_BIT 0
`define NONMASKABLE_IRQ_ENABLE_BIT 1
`define SLEEP_LIGHT 6'h01
`define SLEEP_DEEP_A 6'h11
`define SLEEP_DEEP_B 6'h1a
`define LIGHT_DELAY 4'h8
`define PCG_RESET 32'h00000000
`define CCS_RESET 32'h00000000
`define PERIPH_N 3
`define REARM_CYC 3'h5
`define UNMAPPED_DATA 32'hdeadbeef

`endif

// File: src/pdcc_pkg.sv
/*
  Types shared by the clock and power-down control modules.
  Assumes the constants header is on the include path.
*/
package pdcc_pkg;
  `include "pdcc_consts.svh"

  typedef enum logic [1:0]
  {
    st_run = 2'b00,
    st_arm = 2'b01,
    st_light = 2'b11,
    st_deep = 2'b10
  } pm_state_t;

  typedef enum logic [1:0]
  {
    wake_none = 2'b00,
    wake_resume = 2'b01,
    wake_service = 2'b10
  } wake_kind_t;

  typedef struct packed
  {
    logic [31:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } av_req_t;

  typedef struct packed
  {
    logic [31:0] readdata;
    logic readdatavalid;
    logic waitrequest;
  } av_rsp_t;

  typedef struct packed
  {
    logic [2:0] mult_sel;
    logic full_package;
  } pll_cfg_t;
endpackage

// File: src/power_down_clock_control.sv
/*
  Clock generation control and power-down logic: multiplier selection,
  two sleep modes (light, woken by irq_pending, and deep, left only by reset), peripheral clock gating and the
  Avalon-MM register slave.
  Assumes pins synchronous to core_clk; the PLL itself is analog and
  outside, steered by pll_factor and pll_bypass.
*/
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ns
module power_down_clock_control
  import pdcc_pkg::*;
#(
  parameter int PERIPH_N = `PERIPH_N,
  parameter int FUNC_W = 8
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic reference_clock_input,
  input wire logic multiplier_select_1,
  input wire logic multiplier_select_2,
  input wire logic multiplier_select_0,
  input wire logic full_package,
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic irq_pending,
  input wire logic irq_enabled,
  output logic wake_pulse,
  output logic service_pulse,
  output logic cpu_stall,
  output logic [3:0] pll_factor,
  output logic pll_bypass,
  output logic cpu_clk_en,
  output logic [PERIPH_N-1:0] periph_clk_en,
  output logic [PERIPH_N-1:0] periph_ready,
  input wire logic [PERIPH_N-1:0] periph_wr,
  output logic [PERIPH_N-1:0] periph_wr_ok,
  input wire logic [FUNC_W-1:0] func_out_in,
  output logic [FUNC_W-1:0] func_out,
  output logic sleep_indicator_pin
);
  pll_cfg_t pll_cfg;
  logic [3:0] factor;
  logic bypass;
  logic [3:0] factor_r;
  logic bypass_r;
  logic strap_done_r;
  logic [31:0] gate_r;
  logic [31:0] ccs_r;
  pm_state_t state_r;
  pm_state_t state_nxt;
  logic [3:0] arm_cnt_r;
  logic deep_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic access;
  logic [FUNC_W-1:0] func_r;
  logic [2:0] rearm_cnt_r [PERIPH_N];
  wake_kind_t wake_kind;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a == off);
  endfunction

  assign pll_cfg.mult_sel = {multiplier_select_2, multiplier_select_1, multiplier_select_0};
  assign pll_cfg.full_package = full_package;

  mult_decode u_mult_decode
  (
    .cfg(pll_cfg),
    .factor(factor),
    .bypass(bypass)
  );

  // Mode pins caught once after reset release
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      factor_r <= 4'h1;
      bypass_r <= 1'b1;
      strap_done_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      factor_r <= factor;
      bypass_r <= bypass;
      strap_done_r <= 1'b1;
    end
  end

  assign pll_factor = factor_r;
  assign pll_bypass = bypass_r;

  // Avalon slave: one wait cycle, answer on the second
  assign access = (avs_read || avs_write) && !ack_r;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ack_r <= 1'b0;
    end
    else
    begin
      ack_r <= access;
    end
  end

  // Register writes take effect on the accepting edge
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gate_r <= `PCG_RESET;
    end
    else if (avs_write && ack_r && hit(avs_address, `PCG_OFFSET))
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (avs_byteenable[b])
        begin
          gate_r[b*8 +: 8] <= avs_writedata[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ccs_r <= `CCS_RESET;
    end
    else if (avs_write && ack_r && hit(avs_address, `CCS_OFFSET) && state_r == st_run)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (avs_byteenable[b])
        begin
          ccs_r[b*8 +: 8] <= avs_writedata[b*8 +: 8];
        end
      end
      ccs_r[`SLEEP_RSV] <= 1'b0;
    end
    else if (state_r == st_light && irq_pending)
    begin
      ccs_r[`SLEEP_MSB:`SLEEP_LSB] <= 6'h00;
    end
  end

  always_comb
  begin
    rdata_r = 32'h00000000;
    if (hit(avs_address, `PCG_OFFSET))
    begin
      rdata_r = gate_r;
    end
    else if (hit(avs_address, `CCS_OFFSET))
    begin
      rdata_r = ccs_r;
    end
    else if (hit(avs_address, `STAT_OFFSET))
    begin
      rdata_r = {22'h000000, state_r, factor_r, bypass_r, deep_r, sleep_indicator_pin, cpu_clk_en};
    end
    else
    begin
      rdata_r = `UNMAPPED_DATA;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      avs_readdata <= 32'h00000000;
    end
    else if (access && avs_read)
    begin
      avs_readdata <= rdata_r;
    end
  end

  // Sleep sequencer
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      st_run:
      begin
        if (avs_write && ack_r && hit(avs_address, `CCS_OFFSET) && avs_byteenable[1])
        begin
          if (avs_writedata[`SLEEP_MSB:`SLEEP_LSB] == `SLEEP_DEEP_A
            || avs_writedata[`SLEEP_MSB:`SLEEP_LSB] == `SLEEP_DEEP_B)
          begin
            state_nxt = st_deep;
          end
          else if (avs_writedata[`SLEEP_MSB:`SLEEP_LSB] == `SLEEP_LIGHT)
          begin
            state_nxt = st_arm;
          end
        end
      end
      st_arm:
      begin
        if (arm_cnt_r == `LIGHT_DELAY - 4'h1)
        begin
          state_nxt = st_light;
        end
      end
      st_light:
      begin
        if (irq_pending)
        begin
          state_nxt = st_run;
        end
      end
      st_deep:
      begin
        state_nxt = st_deep;
      end
      default:
      begin
        state_nxt = st_run;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= st_run;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      arm_cnt_r <= 4'h0;
    end
    else if (state_r == st_arm)
    begin
      arm_cnt_r <= arm_cnt_r + 4'h1;
    end
    else
    begin
      arm_cnt_r <= 4'h0;
    end
  end

  always_comb
  begin
    wake_kind = wake_none;
    if (state_r == st_light && irq_pending)
    begin
      if (irq_enabled && ccs_r[`GIE_BIT] && ccs_r[`NONMASKABLE_IRQ_ENABLE_BIT])
      begin
        wake_kind = wake_service;
      end
      else
      begin
        wake_kind = wake_resume;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wake_pulse <= 1'b0;
      service_pulse <= 1'b0;
    end
    else
    begin
      wake_pulse <= (wake_kind != wake_none);
      service_pulse <= (wake_kind == wake_service);
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      deep_r <= 1'b0;
    end
    else
    begin
      deep_r <= (state_nxt == st_deep);
    end
  end

  assign sleep_indicator_pin = deep_r;
  assign cpu_stall = (state_r == st_light) || deep_r;
  assign cpu_clk_en = !deep_r && state_r != st_light;

  // Functional outputs frozen in deep sleep
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      func_r <= '0;
    end
    else if (!deep_r)
    begin
      func_r <= func_out_in;
    end
  end

  assign func_out = func_r;

  // Per peripheral gate, write block and re-enable settle count
  genvar g;
  generate
    for (g = 0; g < PERIPH_N; g++)
    begin : gen_periph
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          rearm_cnt_r[g] <= 3'h0;
        end
        else if (gate_r[g])
        begin
          rearm_cnt_r[g] <= 3'h0;
        end
        else if (rearm_cnt_r[g] != `REARM_CYC)
        begin
          rearm_cnt_r[g] <= rearm_cnt_r[g] + 3'h1;
        end
      end
      assign periph_clk_en[g] = !gate_r[g] && !deep_r;
      assign periph_ready[g] = periph_clk_en[g] && rearm_cnt_r[g] == `REARM_CYC;
      assign periph_wr_ok[g] = periph_wr[g] && periph_clk_en[g];
    end
  endgenerate
endmodule

// File: tb/pdcc_monitor.sv
/*
  Port checker for the clock and power-down control block.
  Assumes binding to power_down_clock_control.
*/
`timescale 1ns/1ns
module pdcc_monitor #(parameter int PERIPH_N = 3, parameter int FUNC_W = 8)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic irq_pending,
  input wire logic wake_pulse,
  input wire logic service_pulse,
  input wire logic cpu_stall,
  input wire logic [3:0] pll_factor,
  input wire logic pll_bypass,
  input wire logic cpu_clk_en,
  input wire logic [PERIPH_N-1:0] periph_clk_en,
  input wire logic [PERIPH_N-1:0] periph_wr,
  input wire logic [PERIPH_N-1:0] periph_wr_ok,
  input wire logic [FUNC_W-1:0] func_out,
  input wire logic sleep_indicator_pin
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  chk_wait_first:
    assert property ((avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest) else $error("no wait");
  chk_wait_one:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("long wait");
  chk_deep_clocks:
    assert property (sleep_indicator_pin |-> !cpu_clk_en && periph_clk_en == '0 && cpu_stall) else $error("clk on");
  chk_deep_stays:
    assert property (sleep_indicator_pin |=> sleep_indicator_pin) else $error("deep left");
  chk_deep_freeze:
    assert property (sleep_indicator_pin |=> $stable(func_out)) else $error("output moved");
  chk_gate_write:
    assert property (periph_wr_ok == (periph_wr & periph_clk_en)) else $error("gated write");
  chk_light_wake:
    assert property (cpu_stall && !sleep_indicator_pin && irq_pending |-> ##[1:2] wake_pulse) else $error("no wake");
  chk_svc_wake:
    assert property (service_pulse |-> wake_pulse) else $error("lone service");
  chk_bypass_x1:
    assert property (pll_bypass == (pll_factor == 4'h1)) else $error("bypass");
endmodule
bind power_down_clock_control pdcc_monitor #(.PERIPH_N(PERIPH_N), .FUNC_W(FUNC_W)) mon (.core_clk(core_clk),
  .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .irq_pending(irq_pending), .wake_pulse(wake_pulse), .service_pulse(service_pulse), .cpu_stall(cpu_stall),
  .pll_factor(pll_factor), .pll_bypass(pll_bypass), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
  .periph_wr(periph_wr), .periph_wr_ok(periph_wr_ok), .func_out(func_out),
  .sleep_indicator_pin(sleep_indicator_pin));

// File: tb/ref_osc.sv
/*
  Free-running reference oscillator model for the clock input.
  Assumes the block only hands this clock on to the PLL.
*/
`timescale 1ns/1ns
module ref_osc #(parameter int HALF_NS = 10)
(
  output logic clk_out
);
  initial
  begin
    clk_out = 1'b0;
    forever #(HALF_NS) clk_out = ~clk_out;
  end
endmodule

// File: tb/testbench.sv
/*
  Self-checking bench for the clock and power-down control block.
  Assumes the design package and the oscillator model.
*/
`timescale 1ns/1ns
`include "pdcc_consts.svh"
module testbench;
  import pdcc_pkg::*;
  localparam logic [31:0] CCS = `CCS_OFFSET;
  localparam logic [31:0] PCG = `PCG_OFFSET;
  localparam logic [3:0] FT [8] = '{4'h1, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb};
  localparam logic [3:0] RT [4] = '{4'h1, 4'h4, 4'h8, 4'ha};
  logic core_clk = 0, resetn = 0, s0 = 0, s1 = 0, s2 = 0, full = 1, rd = 0, wr = 0, irq = 0, ien = 0;
  logic [31:0] adr = 0, wd = 0, rdat, rdata;
  logic wk, svc, stall, byp, cen, ind, wq, ref_clk;
  logic [3:0] fac;
  logic [2:0] pen, prdy, pok, pwr = 0;
  logic [7:0] fin = 0, fout;
  int err_total = 0, n_compared = 0, cyc = 0;
  initial forever #20 core_clk = ~core_clk;
  ref_osc osc (.clk_out(ref_clk));
  power_down_clock_control uut (.core_clk(core_clk), .resetn(resetn), .reference_clock_input(ref_clk),
    .multiplier_select_0(s0), .multiplier_select_1(s1), .multiplier_select_2(s2), .full_package(full),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
    .avs_readdata(rdata), .avs_waitrequest(wq), .irq_pending(irq), .irq_enabled(ien), .wake_pulse(wk),
    .service_pulse(svc), .cpu_stall(stall), .pll_factor(fac), .pll_bypass(byp), .cpu_clk_en(cen),
    .periph_clk_en(pen), .periph_ready(prdy), .periph_wr(pwr), .periph_wr_ok(pok), .func_out_in(fin),
    .func_out(fout), .sleep_indicator_pin(ind));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task do_reset;
    resetn <= 0;
    repeat (20) @(posedge core_clk);
    resetn <= 1;
    @(posedge core_clk);
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    // Values read right after an edge are those that edge sampled
    do
    begin
      @(posedge core_clk);
    end while (wq !== 1'b0);
    rdat = rdata;
    rd <= 0;
    wr <= 0;
  endtask
  task t_regs;
    bus(0, PCG, 0);
    chk(rdat, `PCG_RESET);
    bus(0, CCS, 0);
    chk(rdat, `CCS_RESET);
    bus(0, 32'h019c0300, 0);
    chk(rdat, `UNMAPPED_DATA);
    bus(0, `STAT_OFFSET, 0);
    chk(rdat, 32'h00000019);
    bus(1, CCS, 32'h00008003);
    bus(0, CCS, 0);
    chk(rdat, 32'h00000003);
    $display("register test done");
  endtask
  task t_gate;
    int i;
    logic [2:0] m;
    @(posedge core_clk);
    pwr <= 3'b111;
    for (i = 0; i < 3; i++)
    begin
      m = ~(3'b001 << i);
      bus(1, PCG, 32'h1 << i);
      #1;
      chk(pen, m);
      chk(pok, m);
      bus(0, PCG, 0);
      chk(rdat, 32'h1 << i);
    end
    bus(1, PCG, 0);
    #1;
    chk(prdy[2], 0);
    repeat (6) @(posedge core_clk);
    #1;
    chk(prdy, 3'b111);
    $display("gating test done");
  endtask
  task t_light(input logic [1:0] en, input logic ie, input logic exp_svc);
    int n;
    @(posedge core_clk);
    ien <= ie;
    bus(1, CCS, (32'(`SLEEP_LIGHT) << `SLEEP_LSB) | en);
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
      #1;
    end while (stall !== 1'b1 && n < 20);
    chk(n >= 8 && n <= 9, 1);
    @(posedge core_clk);
    irq <= 1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
      #1;
    end while (wk !== 1'b1 && n < 5);
    chk(wk, 1);
    chk(svc, exp_svc);
    @(posedge core_clk);
    irq <= 0;
    #1;
    chk(stall, 0);
    $display("light sleep test done");
  endtask
  task t_deep(input logic [5:0] code);
    @(posedge core_clk);
    fin <= 8'h5a;
    bus(1, CCS, 32'(code) << `SLEEP_LSB);
    repeat (3) @(posedge core_clk);
    #1;
    chk(ind, 1);
    chk(cen, 0);
    chk(pen, 0);
    chk(fout, 8'h5a);
    @(posedge core_clk);
    fin <= 8'ha5;
    irq <= 1;
    repeat (4) @(posedge core_clk);
    #1;
    chk(fout, 8'h5a);
    chk(stall, 1);
    @(posedge core_clk);
    irq <= 0;
    do_reset;
    #1;
    chk(ind, 0);
    chk(cen, 1);
    $display("deep sleep test done");
  endtask
  task t_mult;
    int k;
    for (k = 0; k < 12; k++)
    begin
      @(posedge core_clk);
      full <= k < 8;
      {s2, s1, s0} <= (k < 8) ? 3'(k) : 3'(k - 4);
      do_reset;
      #1;
      if (k < 8)
        chk(fac, FT[k]);
      else
        chk(fac, RT[k - 8]);
      chk(byp, k == 0 || k == 8);
    end
    $display("multiplier test done");
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      final_report;
    end
  end
  initial
  begin
    do_reset;
    t_regs;
    t_gate;
    t_light(2'b11, 1, 1);
    t_light(2'b01, 1, 0);
    t_light(2'b10, 1, 0);
    t_light(2'b11, 0, 0);
    t_deep(`SLEEP_DEEP_A);
    t_deep(`SLEEP_DEEP_B);
    t_mult;
    final_report;
  end
endmodule
